// [src/aslr_pkg.sv]
// Shared constants and carrier types for the audio slot and limiter register bank
package aslr_pkg;

    // Clock and bus geometry
    localparam int unsigned CLK_HZ      = 10_000_000;
    localparam int unsigned AXI_ADDR_W  = 6;
    localparam int unsigned AXI_DATA_W  = 32;

    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_SAI_CTRL2 = 4'h5;
    localparam logic [3:0] IDX_SUPPLY    = 4'h6;
    localparam logic [3:0] IDX_LIM_CTRL1 = 4'h7;
    localparam logic [3:0] IDX_LIM_CTRL2 = 4'h8;
    localparam logic [3:0] IDX_LIM_CTRL3 = 4'h9;
    localparam logic [3:0] IDX_LIM_STAT  = 4'hA;

    // Reset values
    localparam logic [7:0] RST_SAI_CTRL2 = 8'h00;
    localparam logic [7:0] RST_SUPPLY    = 8'h00;
    localparam logic [7:0] RST_LIM_CTRL1 = 8'hA4;
    localparam logic [7:0] RST_LIM_CTRL2 = 8'h51;
    localparam logic [7:0] RST_LIM_CTRL3 = 8'h22;

    // Writable bit masks; reserved bits are dropped on write
    localparam logic [7:0] MSK_SAI_CTRL2 = 8'h9F;
    localparam logic [7:0] MSK_LIM_CTRL1 = 8'hF7;
    localparam logic [7:0] MSK_LIM_CTRL2 = 8'hFB;
    localparam logic [7:0] MSK_LIM_CTRL3 = 8'hFF;

    // Field positions
    localparam int unsigned SAI_WIDTH_BIT = 7;
    localparam int unsigned SAI_AUTO_BIT  = 4;
    localparam int unsigned SAI_SLOT_LSB  = 0;
    localparam int unsigned LIMITER_RELEASE_RATE_LSB   = 6;
    localparam int unsigned LIMITER_ATTACK_RATE_LSB   = 4;
    localparam int unsigned LIM_TRACK_BIT = 2;
    localparam int unsigned LIM_MODE_LSB  = 0;
    localparam int unsigned LIM_THR_LSB   = 3;
    localparam int unsigned LIM_SLOPE_LSB = 0;
    localparam int unsigned STAT_LOW_BIT  = 0;
    localparam int unsigned STAT_ENG_BIT  = 5;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Sample widths in bits
    localparam logic [4:0] WIDTH_24 = 5'h18;
    localparam logic [4:0] WIDTH_16 = 5'h10;

    // Limiter rates: attack in us per dB, release in ms per dB
    localparam int unsigned ATTACK_US_0  = 120;
    localparam int unsigned ATTACK_US_1  = 60;
    localparam int unsigned ATTACK_US_2  = 30;
    localparam int unsigned ATTACK_US_3  = 20;
    localparam int unsigned RELEASE_MS_0 = 3200;
    localparam int unsigned RELEASE_MS_1 = 1600;
    localparam int unsigned RELEASE_MS_2 = 1200;
    localparam int unsigned RELEASE_MS_3 = 800;
    localparam int unsigned ATTACK_CYC_0  = ATTACK_US_0 * (CLK_HZ / 1_000_000);
    localparam int unsigned ATTACK_CYC_1  = ATTACK_US_1 * (CLK_HZ / 1_000_000);
    localparam int unsigned ATTACK_CYC_2  = ATTACK_US_2 * (CLK_HZ / 1_000_000);
    localparam int unsigned ATTACK_CYC_3  = ATTACK_US_3 * (CLK_HZ / 1_000_000);
    localparam int unsigned RELEASE_CYC_0 = RELEASE_MS_0 * (CLK_HZ / 1_000);
    localparam int unsigned RELEASE_CYC_1 = RELEASE_MS_1 * (CLK_HZ / 1_000);
    localparam int unsigned RELEASE_CYC_2 = RELEASE_MS_2 * (CLK_HZ / 1_000);
    localparam int unsigned RELEASE_CYC_3 = RELEASE_MS_3 * (CLK_HZ / 1_000);
    localparam int unsigned ATK_CYC_W = 11;
    localparam int unsigned REL_CYC_W = 25;

    // Strap pipeline fill before the slot strap is captured
    localparam logic [1:0] STRAP_FILL = 2'h2;
    localparam logic [4:0] THR_MAX    = 5'h1F;

    typedef enum logic [1:0] {
        ASLR_MODE_OFF  = 2'h0,
        ASLR_MODE_ON   = 2'h1,
        ASLR_MODE_MUTE = 2'h2,
        ASLR_MODE_KNEE = 2'h3
    } aslr_mode_t;

    typedef struct packed {
        logic                  awvalid;
        logic [AXI_ADDR_W-1:0] awaddr;
        logic                  wvalid;
        logic [AXI_DATA_W-1:0] wdata;
        logic [3:0]            wstrb;
        logic                  bready;
        logic                  arvalid;
        logic [AXI_ADDR_W-1:0] araddr;
        logic                  rready;
    } aslr_axil_req_t;

    typedef struct packed {
        logic                  awready;
        logic                  wready;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  arready;
        logic                  rvalid;
        logic [AXI_DATA_W-1:0] rdata;
        logic [1:0]            rresp;
    } aslr_axil_rsp_t;

    typedef struct packed {
        logic [4:0] sample_bits;
        logic [3:0] active_slot;
    } aslr_audio_cfg_t;

    typedef struct packed {
        logic [1:0]           release_code;
        logic [1:0]           attack_code;
        logic [REL_CYC_W-1:0] release_step_cyc;
        logic [ATK_CYC_W-1:0] attack_step_cyc;
        logic [4:0]           threshold_code;
        logic                 engaged;
        logic                 mute;
    } aslr_lim_ctl_t;

endpackage : aslr_pkg

// [src/aslr_regs.sv]
// AXI4-Lite register bank for serial audio slot selection and supply-tracking limiter
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps

// What this block does
// - Sample width select bit 0 means 24-bit words, 1 means 16-bit words.
// - With automatic slot select set, the slot comes from the strap pin.
// - Otherwise the four-bit slot field value n selects slot n+1.
// - Supply voltage reading is an 8-bit read-only value; writes are ignored.
// - Release rate from bits 7:6 and attack rate from bits 5:4.
// - Without tracking, attack threshold is the fixed five-bit peak level code.
// - With tracking set (reset state), the threshold follows the supply reading.
// - Mode 00 disables limiting and muting; mode 01 keeps the limiter always on.
// - Mode 10 mutes the output while the supply is below the knee level.
// - Mode 11 engages the limiter only while the supply is below the knee.
// - Threshold drop versus supply drop follows the slope field, 1:1 to 4:1.
// - The knee level is a programmable 8-bit value in supply reading scale.
module aslr_regs
    import aslr_pkg::*;
#(
    parameter int unsigned STRAP_W        = 2,
    parameter int unsigned THR_SHIFT      = 3,
    parameter int unsigned RELEASE_CYC_00 = RELEASE_CYC_0,
    parameter int unsigned RELEASE_CYC_01 = RELEASE_CYC_1,
    parameter int unsigned RELEASE_CYC_10 = RELEASE_CYC_2,
    parameter int unsigned RELEASE_CYC_11 = RELEASE_CYC_3
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                ce,
    input  wire aslr_axil_req_t      axil_req,
    output aslr_axil_rsp_t           axil_rsp,
    input  wire logic [7:0]          supply_sample,
    input  wire logic [STRAP_W-1:0]  slot_strap,
    output aslr_audio_cfg_t          audio_cfg,
    output aslr_lim_ctl_t            lim_ctl,
    output logic                     supply_low
);

    // Strap is zero-extended into the slot index
    if (STRAP_W < 1 || STRAP_W > 4) begin : g_chk_strap
        $error("STRAP_W must lie between 1 and 4");
    end
    if (THR_SHIFT > 7) begin : g_chk_shift
        $error("THR_SHIFT must not exceed 7");
    end
    if (RELEASE_CYC_00 >= (1 << REL_CYC_W) || RELEASE_CYC_01 >= (1 << REL_CYC_W) ||
        RELEASE_CYC_10 >= (1 << REL_CYC_W) || RELEASE_CYC_11 >= (1 << REL_CYC_W)) begin : g_chk_rel
        $error("Release cycle counts do not fit the release step field");
    end

    typedef struct packed {
        aslr_axil_rsp_t        rsp;
        logic                  aw_hold;
        logic [3:0]            aw_idx;
        logic                  w_hold;
        logic [7:0]            w_byte;
        logic                  w_lane0;
        logic [7:0]            sai_ctrl2;
        logic [7:0]            lim_ctrl1;
        logic [7:0]            lim_ctrl2;
        logic [7:0]            lim_ctrl3;
        logic [7:0]            supply_s1;
        logic [7:0]            supply_s2;
        logic [STRAP_W-1:0]    strap_s1;
        logic [STRAP_W-1:0]    strap_s2;
        logic [STRAP_W-1:0]    strap_lat;
        logic [1:0]            strap_cnt;
        logic                  strap_done;
        aslr_audio_cfg_t       audio;
        aslr_lim_ctl_t         lim;
        logic                  low;
    } aslr_state_t;

    localparam aslr_state_t ST_RESET = '{
        rsp:        '0,
        aw_hold:    1'b0,
        aw_idx:     4'h0,
        w_hold:     1'b0,
        w_byte:     8'h00,
        w_lane0:    1'b0,
        sai_ctrl2:  RST_SAI_CTRL2,
        lim_ctrl1:  RST_LIM_CTRL1,
        lim_ctrl2:  RST_LIM_CTRL2,
        lim_ctrl3:  RST_LIM_CTRL3,
        supply_s1:  RST_SUPPLY,
        supply_s2:  RST_SUPPLY,
        strap_s1:   '0,
        strap_s2:   '0,
        strap_lat:  '0,
        strap_cnt:  2'h0,
        strap_done: 1'b0,
        audio:      '{sample_bits: WIDTH_24, active_slot: 4'h0},
        lim:        '0,
        low:        1'b0
    };

    aslr_state_t st_r;
    aslr_state_t st_nxt;

    // Combinational helpers
    logic                 aw_take;
    logic                 w_take;
    logic                 ar_take;
    logic                 have_aw;
    logic                 have_w;
    logic [3:0]           wr_idx;
    logic [7:0]           wr_byte;
    logic                 wr_lane0;
    logic [3:0]           rd_idx;
    logic [7:0]           rd_byte;
    logic                 rd_hit;
    logic                 wr_hit;
    aslr_mode_t           mode;
    logic                 track_on;
    logic [1:0]           slope;
    logic [4:0]           thr_field;
    logic [7:0]           drop;
    logic [9:0]           drop_scaled;
    logic [9:0]           reduction;
    logic [10:0]          thr_sum;
    logic                 below_knee;

    always_comb begin
        st_nxt = st_r;

        // Bus handshakes against the registered ready flags
        aw_take  = axil_req.awvalid & st_r.rsp.awready;
        w_take   = axil_req.wvalid & st_r.rsp.wready;
        ar_take  = axil_req.arvalid & st_r.rsp.arready;
        have_aw  = st_r.aw_hold | aw_take;
        have_w   = st_r.w_hold | w_take;
        wr_idx   = st_r.aw_hold ? st_r.aw_idx : axil_req.awaddr[5:2];
        wr_byte  = st_r.w_hold ? st_r.w_byte : axil_req.wdata[7:0];
        wr_lane0 = st_r.w_hold ? st_r.w_lane0 : axil_req.wstrb[0];
        rd_idx   = axil_req.araddr[5:2];

        if (aw_take) begin
            st_nxt.aw_hold = 1'b1;
            st_nxt.aw_idx  = axil_req.awaddr[5:2];
        end
        if (w_take) begin
            st_nxt.w_hold  = 1'b1;
            st_nxt.w_byte  = axil_req.wdata[7:0];
            st_nxt.w_lane0 = axil_req.wstrb[0];
        end

        // Write commit once address and data are both in hand
        // A pending answer blocks the next commit
        wr_hit = 1'b1;
        if (have_aw && have_w && !st_r.rsp.bvalid) begin
            st_nxt.aw_hold = 1'b0;
            st_nxt.w_hold  = 1'b0;
            case (wr_idx)
                IDX_SAI_CTRL2: begin
                    if (wr_lane0) begin
                        st_nxt.sai_ctrl2 = wr_byte & MSK_SAI_CTRL2;
                    end
                end
                IDX_SUPPLY: begin
                    wr_hit = 1'b1;
                end
                IDX_LIM_CTRL1: begin
                    if (wr_lane0) begin
                        st_nxt.lim_ctrl1 = wr_byte & MSK_LIM_CTRL1;
                    end
                end
                IDX_LIM_CTRL2: begin
                    if (wr_lane0) begin
                        st_nxt.lim_ctrl2 = wr_byte & MSK_LIM_CTRL2;
                    end
                end
                IDX_LIM_CTRL3: begin
                    if (wr_lane0) begin
                        st_nxt.lim_ctrl3 = wr_byte & MSK_LIM_CTRL3;
                    end
                end
                // Status is read-only; writes are accepted and dropped
                IDX_LIM_STAT: begin
                    wr_hit = 1'b1;
                end
                default: begin
                    wr_hit = 1'b0;
                end
            endcase
            st_nxt.rsp.bvalid = 1'b1;
            st_nxt.rsp.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (st_r.rsp.bvalid && axil_req.bready) begin
            st_nxt.rsp.bvalid = 1'b0;
            st_nxt.rsp.bresp  = RESP_OKAY;
        end

        // Read: data captured at the address handshake
        // Latched here so a later write cannot tear it
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        case (rd_idx)
            IDX_SAI_CTRL2: rd_byte = st_r.sai_ctrl2;
            IDX_SUPPLY:    rd_byte = st_r.supply_s2;
            IDX_LIM_CTRL1: rd_byte = st_r.lim_ctrl1;
            IDX_LIM_CTRL2: rd_byte = st_r.lim_ctrl2;
            IDX_LIM_CTRL3: rd_byte = st_r.lim_ctrl3;
            IDX_LIM_STAT: begin
                rd_byte[STAT_LOW_BIT] = st_r.low;
                rd_byte[STAT_ENG_BIT] = st_r.lim.engaged;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
        if (ar_take) begin
            st_nxt.rsp.rvalid = 1'b1;
            st_nxt.rsp.rdata  = {24'h000000, rd_byte};
            st_nxt.rsp.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (st_r.rsp.rvalid && axil_req.rready) begin
            st_nxt.rsp.rvalid = 1'b0;
            st_nxt.rsp.rdata  = '0;
            st_nxt.rsp.rresp  = RESP_OKAY;
        end

        // Ready flags stay low while a channel is held or its answer is pending
        st_nxt.rsp.awready = ~st_nxt.aw_hold & ~st_nxt.rsp.bvalid;
        st_nxt.rsp.wready  = ~st_nxt.w_hold & ~st_nxt.rsp.bvalid;
        st_nxt.rsp.arready = ~st_nxt.rsp.rvalid;

        // Supply reading and strap come from outside the clock domain
        // Only the second stage feeds any logic
        st_nxt.supply_s1 = supply_sample;
        st_nxt.supply_s2 = st_r.supply_s1;
        st_nxt.strap_s1  = slot_strap;
        st_nxt.strap_s2  = st_r.strap_s1;

        // Strap caught once, after the synchroniser has filled past reset
        // A later strap change waits for the next reset
        if (!st_r.strap_done) begin
            if (st_r.strap_cnt == STRAP_FILL) begin
                st_nxt.strap_lat  = st_r.strap_s2;
                st_nxt.strap_done = 1'b1;
            end else begin
                st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
            end
        end

        st_nxt.audio.sample_bits = st_r.sai_ctrl2[SAI_WIDTH_BIT] ? WIDTH_16 : WIDTH_24;

        if (st_r.sai_ctrl2[SAI_AUTO_BIT]) begin
            st_nxt.audio.active_slot = 4'(st_r.strap_lat);
        // Field value n is slot n+1
        end else begin
            st_nxt.audio.active_slot = st_r.sai_ctrl2[SAI_SLOT_LSB +: 4];
        end

        // Release and attack rates
        // Cycles per dB at the nominal clock
        st_nxt.lim.release_code = st_r.lim_ctrl1[LIMITER_RELEASE_RATE_LSB +: 2];
        st_nxt.lim.attack_code  = st_r.lim_ctrl1[LIMITER_ATTACK_RATE_LSB +: 2];
        case (st_r.lim_ctrl1[LIMITER_RELEASE_RATE_LSB +: 2])
            2'h0:    st_nxt.lim.release_step_cyc = REL_CYC_W'(RELEASE_CYC_00);
            2'h1:    st_nxt.lim.release_step_cyc = REL_CYC_W'(RELEASE_CYC_01);
            2'h2:    st_nxt.lim.release_step_cyc = REL_CYC_W'(RELEASE_CYC_10);
            default: st_nxt.lim.release_step_cyc = REL_CYC_W'(RELEASE_CYC_11);
        endcase
        case (st_r.lim_ctrl1[LIMITER_ATTACK_RATE_LSB +: 2])
            2'h0:    st_nxt.lim.attack_step_cyc = ATK_CYC_W'(ATTACK_CYC_0);
            2'h1:    st_nxt.lim.attack_step_cyc = ATK_CYC_W'(ATTACK_CYC_1);
            2'h2:    st_nxt.lim.attack_step_cyc = ATK_CYC_W'(ATTACK_CYC_2);
            default: st_nxt.lim.attack_step_cyc = ATK_CYC_W'(ATTACK_CYC_3);
        endcase

        // Knee comparison on the synchronised reading
        // Equal to the knee counts as healthy
        below_knee    = st_r.supply_s2 < st_r.lim_ctrl3;
        st_nxt.low    = below_knee;
        mode          = aslr_mode_t'(st_r.lim_ctrl1[LIM_MODE_LSB +: 2]);
        track_on      = st_r.lim_ctrl1[LIM_TRACK_BIT];
        slope         = st_r.lim_ctrl2[LIM_SLOPE_LSB +: 2];
        thr_field     = st_r.lim_ctrl2[LIM_THR_LSB +: 5];

        // Drop scaled by slope ratio
        // Shift trades resolution against reach
        drop          = below_knee ? (st_r.lim_ctrl3 - st_r.supply_s2) : 8'h00;
        drop_scaled   = 10'(drop) * 10'({8'h00, slope} + 10'h001);
        reduction     = drop_scaled >> THR_SHIFT;
        thr_sum       = 11'(thr_field) + 11'(reduction);

        if (!track_on) begin
            st_nxt.lim.threshold_code = thr_field;
        // Tracking: higher code is a lower peak level, saturate at the lowest
        end else if (thr_sum > 11'(THR_MAX)) begin
            st_nxt.lim.threshold_code = THR_MAX;
        end else begin
            st_nxt.lim.threshold_code = thr_sum[4:0];
        end

        case (mode)
            ASLR_MODE_OFF: begin
                st_nxt.lim.engaged = 1'b0;
                st_nxt.lim.mute    = 1'b0;
            end
            ASLR_MODE_ON: begin
                st_nxt.lim.engaged = 1'b1;
                st_nxt.lim.mute    = 1'b0;
            end
            ASLR_MODE_MUTE: begin
                st_nxt.lim.engaged = 1'b0;
                st_nxt.lim.mute    = below_knee;
            end
            ASLR_MODE_KNEE: begin
                st_nxt.lim.engaged = below_knee;
                st_nxt.lim.mute    = 1'b0;
            end
            default: begin
                st_nxt.lim.engaged = 1'b0;
                st_nxt.lim.mute    = 1'b0;
            end
        endcase
    end

    // Clock enable low freezes every bit of state, bus handshake included
    // Ready keeps its last value while ce is low: hold off requests
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= ST_RESET;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // Outputs are register copies only
    assign axil_rsp   = st_r.rsp;
    assign audio_cfg  = st_r.audio;
    assign lim_ctl    = st_r.lim;
    assign supply_low = st_r.low;

endmodule : aslr_regs

// [testbench/aslr_regs_chk.sv]
// Port-level assertions for the audio slot and limiter register bank
`timescale 1ns/100ps
module aslr_regs_chk
    import aslr_pkg::*;
#(
    parameter int unsigned STRAP_W = 2
) (
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               ce,
    input wire aslr_axil_req_t     axil_req,
    input wire aslr_axil_rsp_t     axil_rsp,
    input wire logic [7:0]         supply_sample,
    input wire logic [STRAP_W-1:0] slot_strap,
    input wire aslr_audio_cfg_t    audio_cfg,
    input wire aslr_lim_ctl_t      lim_ctl,
    input wire logic               supply_low
);
    // Shadows trail the registers by one edge, just as the derived outputs do
    logic [7:0] sai_r, ctl1_r, ctl2_r, knee_r, wd_r;
    logic [3:0] wa_r, age_r;
    logic       we_r;
    logic       ok;
    assign ok = age_r >= 4'h6;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sai_r  <= 8'h00;
            ctl1_r <= 8'hA4;
            ctl2_r <= 8'h51;
            knee_r <= 8'h22;
            age_r  <= 4'h0;
        end else if (!ce) begin
            // Frozen cycles void the history that $past looks back on
            age_r <= 4'h0;
        end else begin
            age_r <= (age_r == 4'hF) ? age_r : age_r + 4'h1;
            if (axil_req.awvalid && axil_rsp.awready) wa_r <= axil_req.awaddr[5:2];
            if (axil_req.wvalid && axil_rsp.wready) begin
                wd_r <= axil_req.wdata[7:0];
                we_r <= axil_req.wstrb[0];
            end
            if (axil_rsp.bvalid && axil_req.bready && we_r) begin
                case (wa_r)
                    4'h5: sai_r <= wd_r & 8'h9F;
                    4'h7: ctl1_r <= wd_r & 8'hF7;
                    4'h8: ctl2_r <= wd_r & 8'hFB;
                    4'h9: knee_r <= wd_r;
                    default: ;
                endcase
            end
        end
    end

    function automatic logic [10:0] atk(input logic [1:0] c);
        return (c == 2'h0) ? 11'h4B0 : (c == 2'h1) ? 11'h258 : (c == 2'h2) ? 11'h12C : 11'h0C8;
    endfunction : atk

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_width_map: assert property (
        ok |-> audio_cfg.sample_bits == (sai_r[7] ? 5'h10 : 5'h18)) else $error("width wrong");
    a_auto_slot: assert property (
        ok && sai_r[4] |-> audio_cfg.active_slot == 4'(slot_strap)) else $error("strap slot");
    a_field_slot: assert property (
        ok && !sai_r[4] |-> audio_cfg.active_slot == sai_r[3:0]) else $error("field slot");
    a_rate_codes: assert property (
        ok |-> {lim_ctl.release_code, lim_ctl.attack_code} == ctl1_r[7:4]
            && lim_ctl.attack_step_cyc == atk(ctl1_r[5:4])) else $error("rate codes");
    a_thr_plain: assert property (
        ok && !supply_low |-> lim_ctl.threshold_code == ctl2_r[7:3]) else $error("threshold");
    a_mode_off: assert property (
        ok && ctl1_r[1:0] == 2'h0 |-> !lim_ctl.engaged && !lim_ctl.mute) else $error("mode off");
    a_mode_on: assert property (
        ok && ctl1_r[1:0] == 2'h1 |-> lim_ctl.engaged) else $error("mode on");
    a_mute_knee: assert property (
        ok && ctl1_r[1:0] == 2'h2 |-> lim_ctl.mute == supply_low) else $error("mute");
    a_engage_knee: assert property (
        ok && ctl1_r[1:0] == 2'h3 |-> lim_ctl.engaged == supply_low) else $error("engage");
    a_knee_cmp: assert property (
        ok |-> supply_low == ($past(supply_sample, 3) < knee_r)) else $error("knee compare");
    a_read_lat: assert property (
        ce && axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid) else $error("read late");

    c_mute: cover property (ok && lim_ctl.mute);
    c_slverr: cover property (axil_rsp.rvalid && axil_rsp.rresp == RESP_SLVERR);
    c_auto: cover property (ok && sai_r[4]);
endmodule : aslr_regs_chk

// [testbench/audio_slot_limiter_regs_test.sv]
// Self-checking bench for the audio slot and limiter register bank
`timescale 1ns/100ps
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin failures++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, a); end end
module audio_slot_limiter_regs_test
    import aslr_pkg::*;
;
    logic            aclk = 1'b0;
    logic            aresetn = 1'b0;
    logic            ce = 1'b1;
    aslr_axil_req_t  rq = '0;
    aslr_axil_rsp_t  rs;
    logic [7:0]      sup = 8'h30;
    logic [1:0]      strap = 2'h3;
    aslr_audio_cfg_t cfg;
    aslr_lim_ctl_t   lim;
    logic            low;
    logic [7:0]      m [16];
    logic [31:0]     rng = 32'h304D;
    int              failures = 0;
    int              checked = 0;

    always #50 aclk = ~aclk;

    // Release counts shortened so the parameter path is exercised without long runs
    aslr_regs #(.STRAP_W(2), .RELEASE_CYC_00(40), .RELEASE_CYC_01(20),
                .RELEASE_CYC_10(15), .RELEASE_CYC_11(10)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .axil_req(rq), .axil_rsp(rs),
        .supply_sample(sup), .slot_strap(strap), .audio_cfg(cfg), .lim_ctl(lim),
        .supply_low(low));

    function automatic logic [31:0] nx();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : nx

    function automatic logic [7:0] msk(input logic [3:0] ix);
        case (ix)
            4'h5: return 8'h9F;
            4'h7: return 8'hF7;
            4'h8: return 8'hFB;
            4'h9: return 8'hFF;
            default: return 8'h00;
        endcase
    endfunction : msk

    function automatic logic eng();
        return m[7][1:0] == 2'h1 || (m[7][1:0] == 2'h3 && sup < m[9]);
    endfunction : eng

    function automatic logic [4:0] thr();
        int t;
        t = m[8][7:3];
        if (m[7][2] && sup < m[9]) t += (int'(m[9] - sup) * (int'(m[8][1:0]) + 1)) >> 3;
        return (t > 31) ? 5'h1F : 5'(t);
    endfunction : thr

    function automatic logic [31:0] ev(input logic [3:0] ix);
        if (ix == 4'h6) return {24'h0, sup};
        if (ix == 4'hA) return {26'h0, eng(), 4'h0, sup < m[9]};
        return {24'h0, m[ix]};
    endfunction : ev

    function automatic logic [1:0] rsp(input logic [3:0] ix);
        return (ix >= 4'h5 && ix <= 4'hA) ? RESP_OKAY : RESP_SLVERR;
    endfunction : rsp

    task automatic wr(input logic [3:0] ix, input logic [7:0] d, input logic st);
        logic [31:0] r;
        logic        a, w, b;
        r = nx();
        a = 1'b1;
        w = 1'b1;
        b = 1'b1;
        @(posedge aclk);
        rq.awvalid <= 1'b1;
        rq.awaddr  <= {ix, 2'h0};
        rq.wvalid  <= 1'b1;
        rq.wdata   <= {r[31:8], d};
        rq.wstrb   <= {r[3:1], st};
        rq.bready  <= 1'b1;
        for (int n = 0; n < 64 && b; n++) begin
            @(posedge aclk);
            a = a && !rs.awready;
            w = w && !rs.wready;
            b = a || w || !rs.bvalid;
            rq.awvalid <= a;
            rq.wvalid  <= w;
            rq.bready  <= b;
            if (!b) `CHK("bresp", rsp(ix), rs.bresp)
        end
        `CHK("wdone", 1'b0, b)
        // A cleared strobe leaves the register untouched
        if (st) m[ix] = d & msk(ix);
    endtask : wr

    task automatic rd(input logic [3:0] ix);
        logic a, b;
        a = 1'b1;
        b = 1'b1;
        @(posedge aclk);
        rq.arvalid <= 1'b1;
        rq.araddr  <= {ix, 2'h0};
        rq.rready  <= 1'b1;
        for (int n = 0; n < 64 && b; n++) begin
            @(posedge aclk);
            a = a && !rs.arready;
            b = a || !rs.rvalid;
            rq.arvalid <= a;
            rq.rready  <= b;
            if (!b) `CHK("rdata", ev(ix), rs.rdata)
            if (!b) `CHK("rresp", rsp(ix), rs.rresp)
        end
        `CHK("rdone", 1'b0, b)
    endtask : rd

    task automatic outs();
        repeat (6) @(posedge aclk);
        `CHK("width", m[5][7] ? 5'h10 : 5'h18, cfg.sample_bits)
        `CHK("slot", m[5][4] ? 4'(strap) : m[5][3:0], cfg.active_slot)
        `CHK("rates", m[7][7:4], {lim.release_code, lim.attack_code})
        `CHK("atk", m[7][5] ? (m[7][4] ? 11'h0C8 : 11'h12C) : (m[7][4] ? 11'h258 : 11'h4B0), lim.attack_step_cyc)
        `CHK("rel", m[7][7] ? (m[7][6] ? 25'hA : 25'hF) : (m[7][6] ? 25'h14 : 25'h28), lim.release_step_cyc)
        `CHK("low", sup < m[9], low)
        `CHK("thr", thr(), lim.threshold_code)
        `CHK("eng", eng(), lim.engaged)
        `CHK("mute", m[7][1:0] == 2'h2 && sup < m[9], lim.mute)
    endtask : outs

    task automatic rst(input logic [1:0] s);
        @(posedge aclk);
        aresetn <= 1'b0;
        strap   <= s;
        m = '{default: 8'h00};
        m[7] = 8'hA4;
        m[8] = 8'h51;
        m[9] = 8'h22;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        outs();
    endtask : rst

    task automatic end_of_test();
        if (failures == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    initial begin
        logic [31:0] r;
        rst(2'h3);
        for (int i = 5; i < 11; i++) rd(4'(i));
        // Every mode, code and slope, with the supply above and below the knee
        for (int i = 0; i < 16; i++) begin
            sup <= i[3] ? 8'h05 : 8'hF0;
            wr(4'h7, {i[1:0], i[1:0], 1'b1, i[2], i[1:0]}, 1'b1);
            wr(4'h8, {5'(i * 3), 1'b1, i[1:0]}, 1'b1);
            wr(4'h5, {i[0], 2'h3, i[1], 4'(i)}, 1'b1);
            outs();
        end
        for (int i = 0; i < 80; i++) begin
            r = nx();
            if (r[31:29] == 3'h0) sup <= r[15:8];
            wr(r[3:0], r[23:16], r[4] | r[5]);
            rd(r[3:0]);
            if (r[6]) outs();
        end
        // Frozen block keeps supply_low while the supply crosses the knee
        r[0] = sup < m[9];
        ce  <= 1'b0;
        sup <= r[0] ? 8'hFF : 8'h00;
        repeat (8) @(posedge aclk);
        `CHK("hold", r[0], low)
        ce  <= 1'b1;
        outs();
        // Second reset with another strap, then the auto slot path
        rst(2'h1);
        wr(4'h5, 8'h10, 1'b1);
        outs();
        wr(4'h5, 8'h8F, 1'b1);
        outs();
        end_of_test();
    end

    // About twenty times the expected run length
    initial begin
        #2_000_000;
        failures++;
        end_of_test();
    end
endmodule : audio_slot_limiter_regs_test

bind aslr_regs aslr_regs_chk #(.STRAP_W(STRAP_W)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .axil_req(axil_req), .axil_rsp(axil_rsp),
    .supply_sample(supply_sample), .slot_strap(slot_strap), .audio_cfg(audio_cfg),
    .lim_ctl(lim_ctl), .supply_low(supply_low));
